// ===== i2c_irq_pkg.sv
package i2c_irq_pkg;

  // Register byte offsets on the host bus
  localparam logic [7:0] MASKED_STAT_OFS = 8'h2C;
  localparam logic [7:0] MASK_OFS        = 8'h30;
  localparam logic [7:0] RAW_STAT_OFS    = 8'h34;
  localparam logic [7:0] CLEAR_OFS       = 8'h40;
  localparam logic [7:0] CTRL_OFS        = 8'h44;

  // Bit positions in the status, mask, clear and control words
  localparam int RX_UNDER_BIT = 0;
  localparam int RX_OVER_BIT  = 1;
  localparam int RX_FULL_BIT  = 2;
  localparam int TX_OVER_BIT  = 3;
  localparam int RESTART_BIT  = 12;
  localparam int REPORT_EN_BIT = 0;

  // Compact source index order inside the block
  localparam int SRC_RX_UNDER = 0;
  localparam int SRC_RX_OVER  = 1;
  localparam int SRC_RX_FULL  = 2;
  localparam int SRC_TX_OVER  = 3;
  localparam int SRC_RESTART  = 4;
  localparam int NUM_SRC      = 5;

  // Values after reset, in compact source order
  localparam logic [4:0] MASK_RESET      = 5'h0F;
  localparam logic       REPORT_EN_RESET = 1'h0;
  localparam logic [4:0] FLAGS_RESET     = 5'h00;

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_e;

endpackage

// ===== bus_ack.sv
`timescale 1ns/100ps
module bus_ack (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic cyc,
  input  wire logic stb,
  input  wire logic we,
  output logic      take,
  output logic      commit,
  output logic      ack
);

  typedef struct packed {
    i2c_irq_pkg::bus_state_e state;
  } state_s;

  state_s cur_reg;
  state_s cur_next;

  // Answer one cycle after the request is seen, then idle one cycle
  always_comb begin
    cur_next = cur_reg;
    case (cur_reg.state)
      i2c_irq_pkg::BUS_IDLE: begin
        if (cyc && stb) begin
          cur_next.state = i2c_irq_pkg::BUS_ACK;
        end
      end
      i2c_irq_pkg::BUS_ACK: begin
        cur_next.state = i2c_irq_pkg::BUS_IDLE;
      end
      default: begin
        cur_next.state = i2c_irq_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_reg <= '{state: i2c_irq_pkg::BUS_IDLE};
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign take   = cyc && stb && (cur_reg.state == i2c_irq_pkg::BUS_IDLE);
  assign ack    = (cur_reg.state == i2c_irq_pkg::BUS_ACK);
  // Writes land on the edge where the master sees ack
  assign commit = ack && cyc && stb && we;

endmodule

// ===== event_flags.sv
`timescale 1ns/100ps
module event_flags #(
  parameter int N = 5
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] set_pulse,
  input  wire logic [N-1:0] clr_pulse,
  output logic      [N-1:0] flags
);

  typedef struct packed {
    logic [N-1:0] flags_reg;
  } state_s;

  state_s cur_reg;
  state_s cur_next;

  // Set beats clear so an event in the clearing cycle survives
  always_comb begin
    cur_next = cur_reg;
    for (int i = 0; i < N; i++) begin
      if (set_pulse[i]) begin
        cur_next.flags_reg[i] = 1'b1;
      end else if (clr_pulse[i]) begin
        cur_next.flags_reg[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_reg <= '{flags_reg: '0};
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign flags = cur_reg.flags_reg;

endmodule

// ===== i2c_irq_mask_raw_status.sv
// Operation
// R1: Mask bit 3 gates transmit overflow; read-write, resets to one.
// R2: Mask bit 2 gates receive full; read-write, resets to one.
// R3: Mask bit 1 gates receive overflow; read-write, resets to one.
// R4: Mask bit 0 gates receive underflow; read-write, resets to one.
// R5: Raw status at 0x34 shows every source, ignoring the mask.
// R6: Raw bit 12 sets on repeated start while addressed as target.
// R7: Repeated start is reported only while the report enable is one.
// R8: No repeated-start flag in high-speed mode or start-byte transfer.
// R9: Repeated-start flag is read-only, resets to zero, one means active.
// R10: Masked status is raw AND mask; interrupt output is any masked bit.
`timescale 1ns/100ps
module i2c_irq_mask_raw_status (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        tx_over_evt,
  input  wire logic        rx_full_evt,
  input  wire logic        rx_over_evt,
  input  wire logic        rx_under_evt,
  input  wire logic        restart_evt,
  input  wire logic        target_mode,
  input  wire logic        target_addressed,
  input  wire logic        high_speed_mode,
  input  wire logic        start_byte_xfer,
  output logic             intr
);

  localparam int NS = i2c_irq_pkg::NUM_SRC;

  typedef struct packed {
    logic [NS-1:0] mask_reg;
    logic          report_en_reg;
    logic [31:0]   rdata_reg;
    logic          intr_reg;
  } state_s;

  state_s cur_reg;
  state_s cur_next;

  logic          take;
  logic          commit;
  logic [NS-1:0] set_vec;
  logic [NS-1:0] clr_vec;
  logic [NS-1:0] raw_vec;
  logic [NS-1:0] masked_vec;
  logic          restart_qual;

  // Word address compare, byte lanes below bit 2 ignored
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
    reg_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // Spread compact source vector onto register bit positions
  function automatic logic [31:0] to_word(input logic [NS-1:0] v);
    logic [31:0] w;
    w = 32'h00000000;
    w[i2c_irq_pkg::RX_UNDER_BIT] = v[i2c_irq_pkg::SRC_RX_UNDER];
    w[i2c_irq_pkg::RX_OVER_BIT]  = v[i2c_irq_pkg::SRC_RX_OVER];
    w[i2c_irq_pkg::RX_FULL_BIT]  = v[i2c_irq_pkg::SRC_RX_FULL];
    w[i2c_irq_pkg::TX_OVER_BIT]  = v[i2c_irq_pkg::SRC_TX_OVER];
    w[i2c_irq_pkg::RESTART_BIT]  = v[i2c_irq_pkg::SRC_RESTART];
    to_word = w;
  endfunction

  // Gather register bit positions back into source order
  function automatic logic [NS-1:0] from_word(input logic [31:0] w);
    logic [NS-1:0] v;
    v = '0;
    v[i2c_irq_pkg::SRC_RX_UNDER] = w[i2c_irq_pkg::RX_UNDER_BIT];
    v[i2c_irq_pkg::SRC_RX_OVER]  = w[i2c_irq_pkg::RX_OVER_BIT];
    v[i2c_irq_pkg::SRC_RX_FULL]  = w[i2c_irq_pkg::RX_FULL_BIT];
    v[i2c_irq_pkg::SRC_TX_OVER]  = w[i2c_irq_pkg::TX_OVER_BIT];
    v[i2c_irq_pkg::SRC_RESTART]  = w[i2c_irq_pkg::RESTART_BIT];
    from_word = v;
  endfunction

  // Byte enables applied to write data before use
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      m[8*b +: 8] = {8{sel[b]}};
    end
    lane_mask = m;
  endfunction

  bus_ack u_bus_ack (
    .clk    (clk),
    .rst    (rst),
    .cyc    (wb_cyc_i),
    .stb    (wb_stb_i),
    .we     (wb_we_i),
    .take   (take),
    .commit (commit),
    .ack    (wb_ack_o)
  );

  // Restart only counts when addressed as target; in high-speed or
  // start-byte transfers the restart precedes the address.
  assign restart_qual = restart_evt && cur_reg.report_en_reg // R7
                     && target_mode && target_addressed       // R6
                     && !high_speed_mode && !start_byte_xfer; // R8

  always_comb begin
    set_vec = '0;
    set_vec[i2c_irq_pkg::SRC_RX_UNDER] = rx_under_evt;
    set_vec[i2c_irq_pkg::SRC_RX_OVER]  = rx_over_evt;
    set_vec[i2c_irq_pkg::SRC_RX_FULL]  = rx_full_evt;
    set_vec[i2c_irq_pkg::SRC_TX_OVER]  = tx_over_evt;
    set_vec[i2c_irq_pkg::SRC_RESTART]  = restart_qual; // R6
  end

  // Write-one-to-clear; the raw word itself accepts no writes
  assign clr_vec = (commit && reg_hit(wb_adr_i, i2c_irq_pkg::CLEAR_OFS))
                 ? from_word(wb_dat_i & lane_mask(wb_sel_i)) : '0; // R9

  event_flags #(
    .N (NS)
  ) u_event_flags (
    .clk       (clk),
    .rst       (rst),
    .set_pulse (set_vec),
    .clr_pulse (clr_vec),
    .flags     (raw_vec)
  );

  assign masked_vec = raw_vec & cur_reg.mask_reg; // R10

  always_comb begin
    logic [31:0] wmask;
    logic [31:0] rsel;
    wmask = lane_mask(wb_sel_i);
    rsel  = 32'h00000000;
    cur_next = cur_reg;
    // Mask bits change only on the acknowledged write edge
    if (commit && reg_hit(wb_adr_i, i2c_irq_pkg::MASK_OFS)) begin
      cur_next.mask_reg = (cur_reg.mask_reg & ~from_word(wmask))
                        | from_word(wb_dat_i & wmask); // R1 R2 R3 R4
    end
    if (commit && reg_hit(wb_adr_i, i2c_irq_pkg::CTRL_OFS) && wb_sel_i[0]) begin
      cur_next.report_en_reg = wb_dat_i[i2c_irq_pkg::REPORT_EN_BIT]; // R7
    end
    // Read data captured at request time; unmapped reads return zero
    if (reg_hit(wb_adr_i, i2c_irq_pkg::RAW_STAT_OFS)) begin
      rsel = to_word(raw_vec); // R5
    end else if (reg_hit(wb_adr_i, i2c_irq_pkg::MASKED_STAT_OFS)) begin
      rsel = to_word(masked_vec); // R10
    end else if (reg_hit(wb_adr_i, i2c_irq_pkg::MASK_OFS)) begin
      rsel = to_word(cur_reg.mask_reg);
    end else if (reg_hit(wb_adr_i, i2c_irq_pkg::CTRL_OFS)) begin
      rsel[i2c_irq_pkg::REPORT_EN_BIT] = cur_reg.report_en_reg;
    end else begin
      rsel = 32'h00000000;
    end
    if (take && !wb_we_i) begin
      cur_next.rdata_reg = rsel;
    end
    cur_next.intr_reg = |masked_vec; // R10
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_reg <= '{mask_reg:      i2c_irq_pkg::MASK_RESET,
                   report_en_reg: i2c_irq_pkg::REPORT_EN_RESET,
                   rdata_reg:     32'h00000000,
                   intr_reg:      1'b0};
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign wb_dat_o = cur_reg.rdata_reg;
  assign intr     = cur_reg.intr_reg;

  // Helper views for the checks below
  logic mask_write;
  logic clear_write;
  assign mask_write  = commit && reg_hit(wb_adr_i, i2c_irq_pkg::MASK_OFS)
                    && wb_sel_i[0];
  assign clear_write = commit && reg_hit(wb_adr_i, i2c_irq_pkg::CLEAR_OFS);

  sequence seq_mask_write_zero(int b);
    mask_write && !wb_dat_i[b];
  endsequence

  sequence seq_mask_write_one(int b);
    mask_write && wb_dat_i[b];
  endsequence

  a_mask_reset_value: assert property ( // R1
    @(posedge clk) $fell(rst) |-> cur_reg.mask_reg == i2c_irq_pkg::MASK_RESET)
    else $error("mask not at reset value after reset");

  a_tx_over_pass: assert property ( // R1
    @(posedge clk) disable iff (rst)
    raw_vec[i2c_irq_pkg::SRC_TX_OVER] && cur_reg.mask_reg[i2c_irq_pkg::SRC_TX_OVER]
    |=> intr)
    else $error("unmasked tx overflow did not raise intr");

  a_rx_full_hidden: assert property ( // R2
    @(posedge clk) disable iff (rst)
    (raw_vec == (NS'(1) << i2c_irq_pkg::SRC_RX_FULL))
    && !cur_reg.mask_reg[i2c_irq_pkg::SRC_RX_FULL]
    |-> !masked_vec[i2c_irq_pkg::SRC_RX_FULL] ##1 !intr)
    else $error("masked rx full still raised intr");

  a_rx_over_mask: assert property ( // R3
    @(posedge clk) disable iff (rst)
    seq_mask_write_zero(i2c_irq_pkg::RX_OVER_BIT)
    |=> !cur_reg.mask_reg[i2c_irq_pkg::SRC_RX_OVER])
    else $error("rx overflow mask write of zero lost");

  a_rx_under_unmask: assert property ( // R4
    @(posedge clk) disable iff (rst)
    seq_mask_write_one(i2c_irq_pkg::RX_UNDER_BIT)
    |=> cur_reg.mask_reg[i2c_irq_pkg::SRC_RX_UNDER])
    else $error("rx underflow mask write of one lost");

  a_raw_ignores_mask: assert property ( // R5
    @(posedge clk) disable iff (rst)
    take && !wb_we_i && reg_hit(wb_adr_i, i2c_irq_pkg::RAW_STAT_OFS)
    |=> wb_ack_o && wb_dat_o == to_word($past(raw_vec)))
    else $error("raw status read not equal to unmasked flags");

  a_restart_sets: assert property ( // R6
    @(posedge clk) disable iff (rst)
    restart_evt && cur_reg.report_en_reg && target_mode && target_addressed
    && !high_speed_mode && !start_byte_xfer
    |=> raw_vec[i2c_irq_pkg::SRC_RESTART])
    else $error("qualified repeated start did not set flag");

  a_restart_needs_en: assert property ( // R7
    @(posedge clk) disable iff (rst)
    !cur_reg.report_en_reg && !raw_vec[i2c_irq_pkg::SRC_RESTART]
    |=> !raw_vec[i2c_irq_pkg::SRC_RESTART])
    else $error("repeated start flag rose while reporting disabled");

  a_restart_hs_block: assert property ( // R8
    @(posedge clk) disable iff (rst)
    (high_speed_mode || start_byte_xfer) && !raw_vec[i2c_irq_pkg::SRC_RESTART]
    |=> !raw_vec[i2c_irq_pkg::SRC_RESTART])
    else $error("repeated start flagged before address phase");

  a_restart_cause: assert property ( // R9
    @(posedge clk) disable iff (rst)
    $rose(raw_vec[i2c_irq_pkg::SRC_RESTART]) |-> $past(restart_qual))
    else $error("repeated start flag rose without cause");

  a_restart_clear: assert property ( // R9
    @(posedge clk) disable iff (rst)
    clear_write && wb_dat_i[i2c_irq_pkg::RESTART_BIT] && wb_sel_i[1] && !restart_qual
    |=> !raw_vec[i2c_irq_pkg::SRC_RESTART] ##1 !wb_ack_o)
    else $error("repeated start flag not cleared or ack held");

  a_intr_any_masked: assert property ( // R10
    @(posedge clk) disable iff (rst)
    ##1 intr == |$past(masked_vec))
    else $error("intr does not follow masked status");

  // Event path in steps: pulse, raw flag, then registered interrupt
  sequence seq_rx_over_armed;
    rx_over_evt && cur_reg.mask_reg[i2c_irq_pkg::SRC_RX_OVER] && !mask_write;
  endsequence

  sequence seq_flag_then_intr;
    raw_vec[i2c_irq_pkg::SRC_RX_OVER] ##1 intr;
  endsequence

  sequence seq_read_of(logic [7:0] ofs);
    take && !wb_we_i && reg_hit(wb_adr_i, ofs);
  endsequence

  a_event_to_intr: assert property ( // R10
    @(posedge clk) disable iff (rst)
    seq_rx_over_armed |=> seq_flag_then_intr)
    else $error("unmasked rx overflow did not reach intr in two cycles");

  a_tx_over_mask: assert property ( // R1
    @(posedge clk) disable iff (rst)
    seq_mask_write_zero(i2c_irq_pkg::TX_OVER_BIT)
    |=> !cur_reg.mask_reg[i2c_irq_pkg::SRC_TX_OVER])
    else $error("tx overflow mask write of zero lost");

  a_rx_full_unmask: assert property ( // R2
    @(posedge clk) disable iff (rst)
    seq_mask_write_one(i2c_irq_pkg::RX_FULL_BIT)
    |=> cur_reg.mask_reg[i2c_irq_pkg::SRC_RX_FULL])
    else $error("rx full mask write of one lost");

  a_rx_over_unmask: assert property ( // R3
    @(posedge clk) disable iff (rst)
    seq_mask_write_one(i2c_irq_pkg::RX_OVER_BIT)
    |=> cur_reg.mask_reg[i2c_irq_pkg::SRC_RX_OVER])
    else $error("rx overflow mask write of one lost");

  a_rx_under_mask: assert property ( // R4
    @(posedge clk) disable iff (rst)
    seq_mask_write_zero(i2c_irq_pkg::RX_UNDER_BIT)
    |=> !cur_reg.mask_reg[i2c_irq_pkg::SRC_RX_UNDER])
    else $error("rx underflow mask write of zero lost");

  a_mask_readback: assert property ( // R1
    @(posedge clk) disable iff (rst)
    seq_read_of(i2c_irq_pkg::MASK_OFS)
    |=> wb_dat_o == to_word($past(cur_reg.mask_reg)))
    else $error("mask read does not return stored bits");

  a_masked_read: assert property ( // R10
    @(posedge clk) disable iff (rst)
    seq_read_of(i2c_irq_pkg::MASKED_STAT_OFS)
    |=> wb_dat_o == to_word($past(raw_vec) & $past(cur_reg.mask_reg)))
    else $error("masked status read is not raw and mask");

  a_raw_rx_under: assert property ( // R5
    @(posedge clk) disable iff (rst)
    rx_under_evt |=> raw_vec[i2c_irq_pkg::SRC_RX_UNDER])
    else $error("rx underflow event missing from raw status");

  a_raw_tx_over: assert property ( // R5
    @(posedge clk) disable iff (rst)
    tx_over_evt |=> raw_vec[i2c_irq_pkg::SRC_TX_OVER])
    else $error("tx overflow event missing from raw status");

  a_raw_rx_full: assert property ( // R5
    @(posedge clk) disable iff (rst)
    rx_full_evt |=> raw_vec[i2c_irq_pkg::SRC_RX_FULL])
    else $error("rx full event missing from raw status");

  a_restart_holds: assert property ( // R9
    @(posedge clk) disable iff (rst)
    raw_vec[i2c_irq_pkg::SRC_RESTART] && !clear_write
    |=> raw_vec[i2c_irq_pkg::SRC_RESTART])
    else $error("repeated start flag dropped without a clear");

  a_flags_reset: assert property ( // R9
    @(posedge clk) $fell(rst) |-> raw_vec == i2c_irq_pkg::FLAGS_RESET && !intr)
    else $error("flags or intr not clear after reset");

  a_report_en_reset: assert property ( // R7
    @(posedge clk) $fell(rst) |-> cur_reg.report_en_reg == i2c_irq_pkg::REPORT_EN_RESET)
    else $error("report enable not off after reset");

  a_rx_over_clear: assert property ( // R5
    @(posedge clk) disable iff (rst)
    clear_write && wb_sel_i[0] && wb_dat_i[i2c_irq_pkg::RX_OVER_BIT] && !rx_over_evt
    |=> !raw_vec[i2c_irq_pkg::SRC_RX_OVER])
    else $error("rx overflow flag not cleared");

endmodule

// ===== tb.sv
`timescale 1ns/100ps
module tb;
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat;
  logic [31:0] dat_o;
  logic        ack;
  logic [4:0]  ev;
  logic        tmode;
  logic        taddr;
  logic        hs;
  logic        sbyte;
  logic        intr;
  int          n_fail;
  int          tests_run;

  i2c_irq_mask_raw_status u_dut (
    .clk              (clk),
    .rst              (rst),
    .wb_cyc_i         (cyc),
    .wb_stb_i         (stb),
    .wb_we_i          (we),
    .wb_adr_i         (adr),
    .wb_sel_i         (sel),
    .wb_dat_i         (dat),
    .wb_dat_o         (dat_o),
    .wb_ack_o         (ack),
    .tx_over_evt      (ev[3]),
    .rx_full_evt      (ev[2]),
    .rx_over_evt      (ev[1]),
    .rx_under_evt     (ev[0]),
    .restart_evt      (ev[4]),
    .target_mode      (tmode),
    .target_addressed (taddr),
    .high_speed_mode  (hs),
    .start_byte_xfer  (sbyte),
    .intr             (intr)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Holds the request until ack is sampled high; expects ack on the second edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    q = dat_o;
    // Ack one cycle after the take edge, seen on the second edge
    chk("bus ack latency", n, 32'h2);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(nm, q, exp);
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    ev <= 5'h01 << k;
    @(posedge clk);
    ev <= 5'h00;
  endtask

  task automatic t_reset();
    chk("intr after reset", {31'h0, intr}, 32'h0);
    rd("mask reset", i2c_irq_pkg::MASK_OFS, 32'h0000000F);
    rd("raw reset", i2c_irq_pkg::RAW_STAT_OFS, 32'h0);
    rd("masked reset", i2c_irq_pkg::MASKED_STAT_OFS, 32'h0);
    rd("unmapped", 8'h80, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_mask_rw();
    wr(i2c_irq_pkg::MASK_OFS, 32'h0);
    rd("mask clear", i2c_irq_pkg::MASK_OFS, 32'h0);
    wr(i2c_irq_pkg::MASK_OFS, 32'hFFFFFFFF);
    rd("mask set", i2c_irq_pkg::MASK_OFS, 32'h0000100F);
    $display("test mask read-write done");
  endtask

  // Only enabled byte lanes may change mask bits
  task automatic t_lanes();
    logic [31:0] q;
    wr(i2c_irq_pkg::MASK_OFS, 32'h0);
    bus(1'b1, i2c_irq_pkg::MASK_OFS, 32'h0000100F, 4'h1, q);
    rd("mask low lane", i2c_irq_pkg::MASK_OFS, 32'h0000000F);
    bus(1'b1, i2c_irq_pkg::MASK_OFS, 32'h00001000, 4'h2, q);
    rd("mask high lane", i2c_irq_pkg::MASK_OFS, 32'h0000100F);
    $display("test byte lanes done");
  endtask

  // Second reset in mid-run must restore every register
  task automatic t_mid_reset();
    wr(i2c_irq_pkg::CTRL_OFS, 32'h1);
    wr(i2c_irq_pkg::MASK_OFS, 32'h0);
    pulse(0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk("intr mid reset", {31'h0, intr}, 32'h0);
    rd("mask mid reset", i2c_irq_pkg::MASK_OFS, 32'h0000000F);
    rd("raw mid reset", i2c_irq_pkg::RAW_STAT_OFS, 32'h0);
    rd("ctrl mid reset", i2c_irq_pkg::CTRL_OFS, 32'h0);
    pulse(1);
    rd("raw unmasked src", i2c_irq_pkg::RAW_STAT_OFS, 32'h2);
    chk("intr unmasked src", {31'h0, intr}, 32'h1);
    rd("masked unmasked src", i2c_irq_pkg::MASKED_STAT_OFS, 32'h2);
    wr(i2c_irq_pkg::CLEAR_OFS, 32'h2);
    rd("raw after clear", i2c_irq_pkg::RAW_STAT_OFS, 32'h0);
    $display("test mid reset done");
  endtask

  // Bits 0 to 3 of the raw word belong to event inputs 0 to 3
  task automatic t_sources();
    for (int k = 0; k < 4; k++) begin
      wr(i2c_irq_pkg::MASK_OFS, 32'h0);
      pulse(k);
      rd("raw masked src", i2c_irq_pkg::RAW_STAT_OFS, 32'h1 << k);
      rd("masked off", i2c_irq_pkg::MASKED_STAT_OFS, 32'h0);
      chk("intr masked", {31'h0, intr}, 32'h0);
      wr(i2c_irq_pkg::MASK_OFS, 32'h1 << k);
      rd("masked on", i2c_irq_pkg::MASKED_STAT_OFS, 32'h1 << k);
      chk("intr unmasked", {31'h0, intr}, 32'h1);
      wr(i2c_irq_pkg::CLEAR_OFS, 32'h1 << k);
      rd("raw cleared", i2c_irq_pkg::RAW_STAT_OFS, 32'h0);
      chk("intr cleared", {31'h0, intr}, 32'h0);
    end
    $display("test sources done");
  endtask

  task automatic t_restart();
    logic [3:0] bad [4];
    bad = '{4'b0100, 4'b1000, 4'b1110, 4'b1101};
    wr(i2c_irq_pkg::CTRL_OFS, 32'h0);
    {tmode, taddr, hs, sbyte} <= 4'b1100;
    pulse(4);
    rd("restart disabled", i2c_irq_pkg::RAW_STAT_OFS, 32'h0);
    wr(i2c_irq_pkg::CTRL_OFS, 32'h1);
    // Not target, not addressed, high speed, start byte
    for (int i = 0; i < 4; i++) begin
      {tmode, taddr, hs, sbyte} <= bad[i];
      pulse(4);
      rd("restart filtered", i2c_irq_pkg::RAW_STAT_OFS, 32'h0);
    end
    {tmode, taddr, hs, sbyte} <= 4'b1100;
    pulse(4);
    rd("restart seen", i2c_irq_pkg::RAW_STAT_OFS, 32'h00001000);
    chk("intr restart masked", {31'h0, intr}, 32'h0);
    wr(i2c_irq_pkg::RAW_STAT_OFS, 32'h0);
    rd("raw read-only", i2c_irq_pkg::RAW_STAT_OFS, 32'h00001000);
    wr(i2c_irq_pkg::MASK_OFS, 32'h00001000);
    rd("masked restart", i2c_irq_pkg::MASKED_STAT_OFS, 32'h00001000);
    chk("intr restart", {31'h0, intr}, 32'h1);
    wr(i2c_irq_pkg::CLEAR_OFS, 32'h00001000);
    rd("restart cleared", i2c_irq_pkg::RAW_STAT_OFS, 32'h0);
    $display("test restart done");
  endtask

  initial begin
    n_fail = 0;
    tests_run = 0;
    rst = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    ev = 5'h00;
    {tmode, taddr, hs, sbyte} = 4'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mask_rw();
    t_lanes();
    t_sources();
    t_restart();
    t_mid_reset();
    end_of_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
endmodule
